// File: bsm_fifo.sv
// message word fifo with valid/ready on both sides
`timescale 1ns/10ps
module bsm_fifo #(
   parameter int W = 16,
   parameter int D = 8
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic in_valid_i,
   input wire logic [W-1:0] in_data_i,
   output logic in_ready_o,
   output logic out_valid_o,
   output logic [W-1:0] out_data_o,
   input wire logic out_ready_i
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;
   localparam int CW = $clog2(D + 1);
   localparam logic [AW-1:0] LAST = AW'(D - 1);
   localparam logic [CW-1:0] FULL = CW'(D);
   logic [W-1:0] mem_q [D];
   logic [AW-1:0] wp_q, rp_q;
   logic [CW-1:0] cnt_q, cnt_d;
   logic wr, rd;

   assign wr = in_valid_i && in_ready_o;
   assign rd = out_valid_o && out_ready_i;
   assign out_data_o = mem_q[rp_q];

   always_comb begin
      cnt_d = cnt_q;
      if (wr && !rd) cnt_d = cnt_q + 1'b1;
      else if (rd && !wr) cnt_d = cnt_q - 1'b1;
   end

   always_ff @(posedge mclk_i) begin
      if (wr) mem_q[wp_q] <= in_data_i;
   end

   // flags are registered so the ports come from flops
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
         in_ready_o <= 1'b0;
         out_valid_o <= 1'b0;
      end else begin
         if (wr) wp_q <= (wp_q == LAST) ? '0 : wp_q + 1'b1;
         if (rd) rp_q <= (rp_q == LAST) ? '0 : rp_q + 1'b1;
         cnt_q <= cnt_d;
         in_ready_o <= cnt_d != FULL;
         out_valid_o <= cnt_d != '0;
      end
   end
endmodule // bsm_fifo

// File: bsm_gen.sv
// bus status message generator: host requests in, coded messages out
// Function
// - a request not enabled is answered with the not-enabled code only
// - interface faults send their code, light control error, are logged
// - after bus start send start code, run data and messaging channels
// - while running refresh input image and transfer outputs each cycle
// - groups off or segments defective: keep running, light segment off
// - stop halts cyclic traffic and freezes the process data image
// - outputs go safe only by alarm stop or reset, never by a plain stop
// - stop also halts the messaging channel (pcp_run_o off); pending services wait for restart
// - alarm-stop acknowledgment only after the alarm stop is done
// - start refused on board fault, all groups off or bus config changed
// - configuration reply: code, module count, one word per module
// - register count in module's own unit; byte modules set bit 15
// - module codes are listed in installation order
// - register count holds process data words only, no messaging words
// - send configuration-map message when loaded and real config differ
// - group switched on: on code, count one, group number
// - group switch-on failed: failed code, count one, group number
// - group switched off: off code, count one, group number
// - bad group error definition rejected whole: code, two, error, index
// - error number 1 for duplicated elements, 2 for missing group
// - configure-bus acknowledged once executed
// - accepted group error definition gets its own acknowledgment
`timescale 1ns/10ps
module bsm_gen import bsm_pkg::*; #(
   parameter int CYC = CYC_CLKS
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic cmd_valid_i,
   input wire bsm_cmd_t cmd_i,
   output logic cmd_ready_o,
   input wire logic [N_CMD-1:0] cmd_en_i,
   input wire logic flt_valid_i,
   input wire bsm_fk_t flt_kind_i,
   output logic flt_ready_o,
   input wire logic gev_valid_i,
   input wire bsm_gev_t gev_i,
   output logic gev_ready_o,
   input wire logic hw_fault_i,
   input wire logic rbus_changed_i,
   input wire logic seg_defect_i,
   input wire logic map_differs_i,
   input wire logic ctrl_err_clr_i,
   input wire logic cfg_wr_i,
   input wire logic [W_MIX-1:0] cfg_idx_i,
   input wire bsm_mod_t cfg_mod_i,
   input wire logic [W_CNT-1:0] mod_count_i,
   output logic msg_valid_o,
   output logic [15:0] msg_word_o,
   input wire logic msg_ready_i,
   output logic running_o,
   output logic pd_cycle_o,
   output logic pcp_run_o,
   output logic out_safe_o,
   output logic seg_off_o,
   output logic ctrl_err_o,
   output logic [7:0] diag_count_o,
   output logic [15:0] diag_last_o,
   output logic [N_GRP-1:0] grp_on_o,
   output logic [N_GRP-1:0] grp_crit_o
);
   localparam logic [15:0] GRP_LIM = 16'(N_GRP);
   localparam int DW = $clog2(CYC + 1);
   localparam logic [DW-1:0] CYC_LAST = DW'(CYC - 1);
   bsm_st_t st_q;
   bsm_ck_t ck;
   bsm_cfgw_t mtab_q [N_MOD];
   logic flt_take, gev_take, cmd_take, quiet, map_go, map_pend_q, map_prev_q;
   logic ld, ld_phys, do_start, do_stop, do_alarm, do_grperr, do_flt;
   logic [15:0] ld_code, ld_p0, ld_p1, word, mcode_q, p0_q, p1_q;
   logic [W_CNT-1:0] ld_cnt, mcnt_q, widx_q;
   logic [DW-1:0] div_q;
   logic phys_q, fifo_rdy, push, last, tick;
   assign flt_take = flt_ready_o && flt_valid_i;
   assign gev_take = gev_ready_o && gev_valid_i;
   assign cmd_take = cmd_ready_o && cmd_valid_i;
   assign quiet = st_q == S_IDLE && !flt_ready_o && !gev_ready_o
      && !cmd_ready_o;
   assign map_go = quiet && !flt_valid_i && !gev_valid_i && !cmd_valid_i
      && map_pend_q;
   always_comb begin
      unique case (cmd_i.code)
         RQ_START: ck = CK_START;
         RQ_STOP: ck = CK_STOP;
         RQ_ALARM: ck = CK_ALARM;
         RQ_PHYS: ck = CK_PHYS;
         RQ_CFGBUS: ck = CK_CFGBUS;
         RQ_GRPERR: ck = CK_GRPERR;
         default: ck = CK_NONE;
      endcase
   end
   // one source granted at a time; faults first, then group events
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         flt_ready_o <= 1'b0;
         gev_ready_o <= 1'b0;
         cmd_ready_o <= 1'b0;
      end else if (quiet) begin
         flt_ready_o <= flt_valid_i;
         gev_ready_o <= !flt_valid_i && gev_valid_i;
         cmd_ready_o <= !flt_valid_i && !gev_valid_i && cmd_valid_i;
      end else if (ld) begin
         flt_ready_o <= 1'b0;
         gev_ready_o <= 1'b0;
         cmd_ready_o <= 1'b0;
      end
   end
   always_comb begin
      ld = 1'b0;
      ld_phys = 1'b0;
      ld_code = '0;
      ld_cnt = '0;
      ld_p0 = '0;
      ld_p1 = '0;
      do_start = 1'b0;
      do_stop = 1'b0;
      do_alarm = 1'b0;
      do_grperr = 1'b0;
      do_flt = 1'b0;
      if (flt_take) begin
         ld = 1'b1;
         do_flt = 1'b1;
         unique case (flt_kind_i)
            FK_NOCMD: ld_code = MSG_NOCMD;
            FK_PWR: ld_code = MSG_PWR;
            FK_CTMO: ld_code = MSG_CTMO;
            FK_HTMO: ld_code = MSG_HTMO;
            default: ld_code = MSG_PARM;
         endcase
      end else if (gev_take) begin
         ld = 1'b1;
         ld_cnt = CNT_ONE;
         ld_p0 = {8'h00, gev_i.grp};
         unique case (gev_i.kind)
            GE_ON: ld_code = MSG_GON;
            GE_OFF: ld_code = MSG_GOFF;
            default: ld_code = MSG_GFAIL;
         endcase
      end else if (cmd_take) begin
         ld = 1'b1;
         if (ck == CK_NONE) begin
            ld_code = MSG_NOCMD;
            do_flt = 1'b1;
         end else if (!cmd_en_i[ck]) begin
            ld_code = MSG_DISABLED;
         end else begin
            unique case (ck)
               CK_START: begin
                  if (hw_fault_i || rbus_changed_i || grp_on_o == '0) begin
                     ld_code = MSG_NOSTART;
                  end else begin
                     ld_code = MSG_START;
                     do_start = 1'b1;
                  end
               end
               CK_STOP: begin
                  ld_code = MSG_STOP;
                  do_stop = 1'b1;
               end
               CK_ALARM: begin
                  ld_code = MSG_ALARM;
                  do_alarm = 1'b1;
               end
               CK_PHYS: begin
                  ld_code = MSG_PHYS;
                  ld_cnt = mod_count_i;
                  ld_phys = 1'b1;
               end
               CK_CFGBUS: ld_code = MSG_QCFG;
               CK_GRPERR: begin
                  ld_code = MSG_GRPFAIL;
                  ld_cnt = CNT_TWO;
                  if (cmd_i.arg0 >= GRP_LIM) begin
                     ld_p0 = ERN_NOGRP;
                     ld_p1 = PARAM_1;
                  end else if (cmd_i.arg1 >= GRP_LIM) begin
                     ld_p0 = ERN_NOGRP;
                     ld_p1 = PARAM_2;
                  end else if (cmd_i.arg0 == cmd_i.arg1) begin
                     ld_p0 = ERN_DUP;
                     ld_p1 = PARAM_2;
                  end else begin
                     ld_code = MSG_QGRPERR;
                     ld_cnt = '0;
                     do_grperr = 1'b1;
                  end
               end
               CK_NONE: ld_code = MSG_NOCMD;
            endcase
         end
      end else if (map_go) begin
         ld = 1'b1;
         ld_code = MSG_MAP;
      end
   end
   // configuration map mismatch: edge sets a pending flag, set wins
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         map_prev_q <= 1'b0;
         map_pend_q <= 1'b0;
      end else begin
         map_prev_q <= map_differs_i;
         if (map_differs_i && !map_prev_q) map_pend_q <= 1'b1;
         else if (map_go) map_pend_q <= 1'b0;
      end
   end
   always_ff @(posedge mclk_i) begin
      if (cfg_wr_i) begin
         mtab_q[cfg_idx_i].byte_mode <= cfg_mod_i.byte_mode;
         mtab_q[cfg_idx_i].regs <= cfg_mod_i.pd_regs;
         mtab_q[cfg_idx_i].id <= cfg_mod_i.id;
      end
   end
   // bus operating state; actions complete before the reply is queued
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         running_o <= 1'b0;
         pcp_run_o <= 1'b0;
         out_safe_o <= 1'b1;
      end else if (do_start) begin
         running_o <= 1'b1;
         pcp_run_o <= 1'b1;
         out_safe_o <= 1'b0;
      end else if (do_alarm) begin
         running_o <= 1'b0;
         pcp_run_o <= 1'b0;
         out_safe_o <= 1'b1;
      end else if (do_stop) begin
         running_o <= 1'b0;
         pcp_run_o <= 1'b0;
      end
   end
   // cycle divider; no refresh while stopped so the image stays frozen
   assign tick = div_q == CYC_LAST;
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         div_q <= '0;
         pd_cycle_o <= 1'b0;
      end else begin
         div_q <= tick ? '0 : div_q + 1'b1;
         pd_cycle_o <= tick && running_o;
      end
   end
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         grp_on_o <= GRP_ON_RST;
         seg_off_o <= 1'b0;
      end else begin
         if (gev_take && gev_i.grp < 8'(N_GRP)) begin
            if (gev_i.kind == GE_ON) grp_on_o[gev_i.grp[2:0]] <= 1'b1;
            else if (gev_i.kind == GE_OFF) grp_on_o[gev_i.grp[2:0]] <= 1'b0;
         end
         seg_off_o <= running_o && (grp_on_o != GRP_ON_RST
            || seg_defect_i);
      end
   end
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         grp_crit_o <= '0;
      end else if (do_grperr) begin
         grp_crit_o[cmd_i.arg0[2:0]] <= 1'b1;
         grp_crit_o[cmd_i.arg1[2:0]] <= 1'b1;
      end
   end
   // control error and diagnostic log; a new fault beats the clear
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         ctrl_err_o <= 1'b0;
         diag_count_o <= '0;
         diag_last_o <= '0;
      end else begin
         if (do_flt) begin
            ctrl_err_o <= 1'b1;
            diag_count_o <= diag_count_o + 1'b1;
            diag_last_o <= ld_code;
         end else if (ctrl_err_clr_i) begin
            ctrl_err_o <= 1'b0;
         end
      end
   end
   assign push = st_q == S_EMIT;
   assign last = widx_q == mcnt_q + CNT_ONE;
   always_comb begin
      if (widx_q == IDX_CODE) word = mcode_q;
      else if (widx_q == IDX_CNT) word = {11'h000, mcnt_q};
      else if (phys_q) word = mtab_q[W_MIX'(widx_q - IDX_P0)];
      else if (widx_q == IDX_P0) word = p0_q;
      else word = p1_q;
   end
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         st_q <= S_IDLE;
         widx_q <= '0;
         mcode_q <= '0;
         mcnt_q <= '0;
         p0_q <= '0;
         p1_q <= '0;
         phys_q <= 1'b0;
      end else if (ld) begin
         st_q <= S_EMIT;
         widx_q <= IDX_CODE;
         mcode_q <= ld_code;
         mcnt_q <= ld_cnt;
         p0_q <= ld_p0;
         p1_q <= ld_p1;
         phys_q <= ld_phys;
      end else if (push && fifo_rdy) begin
         widx_q <= widx_q + 1'b1;
         if (last) st_q <= S_IDLE;
      end
   end
   // a full fifo stalls the emitter, which holds off new requests
   bsm_fifo #(.W(16), .D(FIFO_D)) u_fifo (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .in_valid_i(push),
      .in_data_i(word),
      .in_ready_o(fifo_rdy),
      .out_valid_o(msg_valid_o),
      .out_data_o(msg_word_o),
      .out_ready_i(msg_ready_i)
   );
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   chk_disabled_reply: assert property (
      cmd_take && ck != CK_NONE && !cmd_en_i[ck] |=>
      mcode_q == MSG_DISABLED && $stable(running_o) && $stable(out_safe_o))
      else $error("disabled request not refused");
   chk_fault_log: assert property (
      flt_take |=> ctrl_err_o && diag_last_o == mcode_q
      && diag_count_o == $past(diag_count_o) + 8'h01)
      else $error("fault not logged");
   chk_start_run: assert property (
      do_start |=> running_o && pcp_run_o && mcode_q == MSG_START)
      else $error("start did not run bus");
   chk_cycle_gate: assert property (pd_cycle_o |-> $past(running_o))
      else $error("refresh while stopped");
   chk_seg_off: assert property (
      running_o && seg_defect_i |=> seg_off_o)
      else $error("segment off not lit");
   chk_safe_cause: assert property (
      $rose(out_safe_o) |-> $past(do_alarm))
      else $error("safe state without alarm stop");
   chk_alarm_ack: assert property (
      do_alarm |=> out_safe_o && !running_o && mcode_q == MSG_ALARM)
      else $error("alarm ack before completion");
   chk_no_start: assert property (
      cmd_take && ck == CK_START && cmd_en_i[ck] && hw_fault_i |=>
      mcode_q == MSG_NOSTART && running_o == $past(running_o))
      else $error("start not refused on fault");
   chk_grp_on: assert property (
      gev_take && gev_i.kind == GE_ON |=> mcode_q == MSG_GON
      && mcnt_q == CNT_ONE && p0_q[7:0] == $past(gev_i.grp))
      else $error("group on reply wrong");
   chk_grperr_reject: assert property (
      ld && ld_code == MSG_GRPFAIL |=> $stable(grp_crit_o)
      && mcnt_q == CNT_TWO)
      else $error("failed definition stored");
   chk_one_msg: assert property (
      st_q == S_EMIT |-> !flt_ready_o && !gev_ready_o && !cmd_ready_o)
      else $error("request taken mid message");
   cov_start: cover property (do_start ##[1:40] do_stop);
   cov_phys: cover property (ld_phys ##[1:60] (st_q == S_IDLE));
   cov_grperr: cover property (ld && ld_code == MSG_GRPFAIL);
endmodule // bsm_gen

// File: bsm_gen_test.sv
// self-checking testbench of the bus status message generator
`timescale 1ns/10ps
module bsm_gen_test;
   import bsm_pkg::*;
   localparam int CYC_T = 4;
   logic mclk_i = 1'b0;
   logic rst_n_i, cmd_valid_i, flt_valid_i, gev_valid_i, hw_fault_i;
   logic rbus_changed_i, seg_defect_i, map_differs_i, ctrl_err_clr_i;
   logic cfg_wr_i, msg_ready_i, slow;
   bsm_cmd_t cmd_i;
   logic [N_CMD-1:0] cmd_en_i;
   bsm_fk_t flt_kind_i;
   bsm_gev_t gev_i;
   logic [W_MIX-1:0] cfg_idx_i;
   bsm_mod_t cfg_mod_i;
   logic [W_CNT-1:0] mod_count_i;
   logic cmd_ready_o, flt_ready_o, gev_ready_o, msg_valid_o, running_o;
   logic pd_cycle_o, pcp_run_o, out_safe_o, seg_off_o, ctrl_err_o;
   logic [7:0] diag_count_o;
   logic [15:0] diag_last_o, msg_word_o;
   logic [N_GRP-1:0] grp_on_o, grp_crit_o;
   logic [15:0] exp_q[$];
   logic [31:0] seed = 32'he5292d7b;
   logic [15:0] ga[4] = '{16'h0003, 16'h0009, 16'h0001, 16'h0002};
   logic [15:0] gb[4] = '{16'h0003, 16'h0001, 16'h000c, 16'h0005};
   logic [15:0] ge[4] = '{16'h0001, 16'h0002, 16'h0002, 16'h0000};
   logic [15:0] gp[4] = '{16'h0002, 16'h0001, 16'h0002, 16'h0000};
   int err_count = 0;
   int total_checks = 0;
   int i, j, np;
   logic [7:0] g;

   bsm_gen #(.CYC(CYC_T)) bsm_gen_i (.mclk_i, .rst_n_i, .cmd_valid_i,
      .cmd_i, .cmd_ready_o, .cmd_en_i, .flt_valid_i, .flt_kind_i,
      .flt_ready_o, .gev_valid_i, .gev_i, .gev_ready_o, .hw_fault_i,
      .rbus_changed_i, .seg_defect_i, .map_differs_i, .ctrl_err_clr_i,
      .cfg_wr_i, .cfg_idx_i, .cfg_mod_i, .mod_count_i, .msg_valid_o,
      .msg_word_o, .msg_ready_i, .running_o, .pd_cycle_o, .pcp_run_o,
      .out_safe_o, .seg_off_o, .ctrl_err_o, .diag_count_o, .diag_last_o,
      .grp_on_o, .grp_crit_o);
   bsm_host bsm_host_i (.mclk_i, .rst_n_i, .slow_i(slow),
      .msg_valid_i(msg_valid_o), .msg_word_i(msg_word_o),
      .msg_ready_o(msg_ready_i));

   always #10 mclk_i = ~mclk_i;

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [15:0] fcode(input int k);
      case (k)
         0: return MSG_NOCMD;
         1: return MSG_PWR;
         2: return MSG_CTMO;
         3: return MSG_HTMO;
         default: return MSG_PARM;
      endcase
   endfunction
   function automatic logic rdy(input int k);
      return k == 0 ? cmd_ready_o : k == 1 ? flt_ready_o : gev_ready_o;
   endfunction

   task automatic chk(input string nm, input logic [15:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // valid is held until ready is seen, released one edge after the take
   task automatic hs(input int k);
      int n;
      @(negedge mclk_i);
      cmd_valid_i = (k == 0);
      flt_valid_i = (k == 1);
      gev_valid_i = (k == 2);
      n = 0;
      while (!rdy(k) && n < 100) begin
         @(negedge mclk_i);
         n++;
      end
      chk("request taken", 16'(rdy(k)), 16'h0001);
      @(negedge mclk_i);
      cmd_valid_i = 1'b0;
      flt_valid_i = 1'b0;
      gev_valid_i = 1'b0;
   endtask
   task automatic cmd(input logic [15:0] c, a, b);
      cmd_i = '{c, a, b};
      hs(0);
   endtask
   // extra words are caught by waiting past the expected length
   task automatic expect_msg(input string nm);
      int n;
      n = 0;
      while (bsm_host_i.rx_q.size() < exp_q.size() && n < 400) begin
         @(negedge mclk_i);
         n++;
      end
      repeat (8) @(negedge mclk_i);
      chk({nm, " length"}, 16'(bsm_host_i.rx_q.size()),
         16'(exp_q.size()));
      while (exp_q.size() > 0 && bsm_host_i.rx_q.size() > 0) begin
         chk(nm, bsm_host_i.rx_q.pop_front(), exp_q.pop_front());
      end
      exp_q.delete();
      bsm_host_i.rx_q.delete();
      $display("test %s done", nm);
   endtask
   task automatic count_pd(input int cyc);
      np = 0;
      repeat (cyc) begin
         @(negedge mclk_i);
         if (pd_cycle_o === 1'b1) np++;
      end
   endtask

   initial begin
      #(20 * 30000);
      err_count++;
      $display("watchdog expired");
      close_out();
   end

   initial begin
      {rst_n_i, cmd_valid_i, flt_valid_i, gev_valid_i, hw_fault_i} = '0;
      {rbus_changed_i, seg_defect_i, map_differs_i, ctrl_err_clr_i} = '0;
      {cfg_wr_i, slow, cfg_idx_i, mod_count_i} = '0;
      cmd_i = '0;
      gev_i = '0;
      cfg_mod_i = '0;
      flt_kind_i = FK_NOCMD;
      cmd_en_i = '1;
      repeat (4) @(negedge mclk_i);
      rst_n_i = 1'b1;
      chk("out_safe", 16'(out_safe_o), 16'h0001);
      chk("grp_on", 16'(grp_on_o), 16'(GRP_ON_RST));
      cmd_en_i[CK_START] = 1'b0;
      cmd(RQ_START, 16'h0000, 16'h0000);
      exp_q = '{MSG_DISABLED, 16'h0000};
      expect_msg("disabled");
      chk("running", 16'(running_o), 16'h0000);
      cmd_en_i = '1;
      for (i = 0; i < 2; i++) begin
         hw_fault_i = (i == 0);
         rbus_changed_i = (i == 1);
         cmd(RQ_START, 16'h0000, 16'h0000);
         exp_q = '{MSG_NOSTART, 16'h0000};
         expect_msg("refused");
         chk("running", 16'(running_o), 16'h0000);
      end
      {hw_fault_i, rbus_changed_i} = '0;
      slow = 1'b1;
      cmd(RQ_START, 16'h0000, 16'h0000);
      exp_q = '{MSG_START, 16'h0000};
      expect_msg("start");
      chk("running", 16'(running_o), 16'h0001);
      chk("pcp_run", 16'(pcp_run_o), 16'h0001);
      count_pd(10 * CYC_T);
      chk("pd_cycle", 16'(np), 16'h000a);
      seg_defect_i = 1'b1;
      repeat (2) @(negedge mclk_i);
      chk("seg_off", 16'(seg_off_o), 16'h0001);
      chk("running", 16'(running_o), 16'h0001);
      seg_defect_i = 1'b0;
      g = 8'(rnd() % 8);
      for (i = 0; i < 3; i++) begin
         gev_i = '{i == 0 ? GE_OFF : i == 1 ? GE_FAIL : GE_ON, g};
         hs(2);
         exp_q = '{i == 0 ? MSG_GOFF : i == 1 ? MSG_GFAIL : MSG_GON,
            16'h0001, {8'h00, g}};
         expect_msg("group");
         chk("grp_on", 16'(grp_on_o[g[2:0]]), 16'(i == 2));
         chk("seg_off", 16'(seg_off_o), 16'(i != 2));
      end
      mod_count_i = 5'(1 + rnd() % 16);
      exp_q = '{MSG_PHYS, {11'h000, mod_count_i}};
      for (j = 0; j < mod_count_i; j++) begin
         @(negedge mclk_i);
         cfg_mod_i = (j == 0) ? 20'hfffff : 20'(rnd());
         cfg_idx_i = 4'(j);
         cfg_wr_i = 1'b1;
         exp_q.push_back({cfg_mod_i.byte_mode, cfg_mod_i.pd_regs,
            cfg_mod_i.id});
      end
      @(negedge mclk_i);
      cfg_wr_i = 1'b0;
      cmd(RQ_PHYS, 16'h0000, 16'h0000);
      expect_msg("config");
      cmd(RQ_CFGBUS, 16'h0000, 16'h0000);
      exp_q = '{MSG_QCFG, 16'h0000};
      expect_msg("configure");
      for (i = 0; i < 4; i++) begin
         cmd(RQ_GRPERR, ga[i], gb[i]);
         if (i < 3) exp_q = '{MSG_GRPFAIL, 16'h0002, ge[i], gp[i]};
         else exp_q = '{MSG_QGRPERR, 16'h0000};
         expect_msg("group error");
         if (i < 3) chk("grp_crit", 16'(grp_crit_o), 16'h0000);
         else chk("grp_crit", 16'(grp_crit_o), 16'h0024);
      end
      map_differs_i = 1'b1;
      exp_q = '{MSG_MAP, 16'h0000};
      expect_msg("map");
      map_differs_i = 1'b0;
      for (i = 0; i < 5; i++) begin
         flt_kind_i = bsm_fk_t'(i);
         hs(1);
         exp_q = '{fcode(i), 16'h0000};
         expect_msg("fault");
         chk("ctrl_err", 16'(ctrl_err_o), 16'h0001);
         chk("diag_count", 16'(diag_count_o), 16'(i + 1));
         chk("diag_last", diag_last_o, fcode(i));
      end
      cmd(16'h0077, 16'h0000, 16'h0000);
      exp_q = '{MSG_NOCMD, 16'h0000};
      expect_msg("unknown");
      chk("diag_count", 16'(diag_count_o), 16'h0006);
      ctrl_err_clr_i = 1'b1;
      @(negedge mclk_i);
      ctrl_err_clr_i = 1'b0;
      @(negedge mclk_i);
      chk("ctrl_err", 16'(ctrl_err_o), 16'h0000);
      cmd(RQ_STOP, 16'h0000, 16'h0000);
      exp_q = '{MSG_STOP, 16'h0000};
      expect_msg("stop");
      chk("running", 16'(running_o), 16'h0000);
      chk("out_safe", 16'(out_safe_o), 16'h0000);
      count_pd(3 * CYC_T);
      chk("pd_cycle", 16'(np), 16'h0000);
      cmd(RQ_START, 16'h0000, 16'h0000);
      exp_q = '{MSG_START, 16'h0000};
      expect_msg("restart");
      chk("pcp_run", 16'(pcp_run_o), 16'h0001);
      cmd(RQ_ALARM, 16'h0000, 16'h0000);
      exp_q = '{MSG_ALARM, 16'h0000};
      expect_msg("alarm");
      chk("out_safe", 16'(out_safe_o), 16'h0001);
      close_out();
   end
endmodule // bsm_gen_test

// File: bsm_host.sv
// host model: pops message words, promptly or with stalls
`timescale 1ns/10ps
module bsm_host (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic slow_i,
   input wire logic msg_valid_i,
   input wire logic [15:0] msg_word_i,
   output logic msg_ready_o
);
   logic [15:0] rx_q[$];
   logic [2:0] stall_q;
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         msg_ready_o <= 1'b0;
         stall_q <= 3'h5;
      end else begin
         // irregular stalls keep the fifo's back-pressure path busy
         stall_q <= {stall_q[1:0], stall_q[2] ^ stall_q[1]};
         msg_ready_o <= !slow_i || stall_q[0];
      end
   end
   // words are taken strictly in order, whole messages before the next
   always @(posedge mclk_i) begin
      if (rst_n_i && msg_valid_i && msg_ready_o) begin
         rx_q.push_back(msg_word_i);
      end
   end
endmodule // bsm_host

// File: bsm_pkg.sv
// package: codes, carriers and timing for the bus status message block
package bsm_pkg;
   // timing
   localparam int CLK_NS = 20;
   localparam int CYC_NS = 1000;
   localparam int CYC_CLKS = (CYC_NS + CLK_NS - 1) / CLK_NS;
   // sizes
   localparam int N_GRP = 8;
   localparam int N_MOD = 16;
   localparam int FIFO_D = 8;
   localparam int W_CNT = 5;
   localparam int W_MIX = 4;
   // request codes from the host
   localparam logic [15:0] RQ_START = 16'h0001;
   localparam logic [15:0] RQ_STOP = 16'h0002;
   localparam logic [15:0] RQ_CFGBUS = 16'h0023;
   localparam logic [15:0] RQ_ALARM = 16'h004a;
   localparam logic [15:0] RQ_PHYS = 16'h0050;
   localparam logic [15:0] RQ_GRPERR = 16'h0060;
   // message codes to the host
   localparam logic [15:0] MSG_DISABLED = 16'h009c;
   localparam logic [15:0] MSG_NOCMD = 16'h0007;
   localparam logic [15:0] MSG_PWR = 16'h0009;
   localparam logic [15:0] MSG_CTMO = 16'h000c;
   localparam logic [15:0] MSG_HTMO = 16'h000d;
   localparam logic [15:0] MSG_PARM = 16'h004b;
   localparam logic [15:0] MSG_START = 16'h0088;
   localparam logic [15:0] MSG_STOP = 16'h00c6;
   localparam logic [15:0] MSG_ALARM = 16'h00d8;
   localparam logic [15:0] MSG_NOSTART = 16'h00e3;
   localparam logic [15:0] MSG_PHYS = 16'h80f4;
   localparam logic [15:0] MSG_QCFG = 16'h00ab;
   localparam logic [15:0] MSG_MAP = 16'h00ca;
   localparam logic [15:0] MSG_GON = 16'h809e;
   localparam logic [15:0] MSG_GFAIL = 16'h80c5;
   localparam logic [15:0] MSG_GOFF = 16'h809d;
   localparam logic [15:0] MSG_QGRPERR = 16'h00f6;
   localparam logic [15:0] MSG_GRPFAIL = 16'h80f7;
   // parameter words
   localparam logic [15:0] ERN_DUP = 16'h0001;
   localparam logic [15:0] ERN_NOGRP = 16'h0002;
   localparam logic [15:0] PARAM_1 = 16'h0001;
   localparam logic [15:0] PARAM_2 = 16'h0002;
   localparam logic [W_CNT-1:0] CNT_ONE = 5'h01;
   localparam logic [W_CNT-1:0] CNT_TWO = 5'h02;
   localparam logic [W_CNT-1:0] IDX_CODE = 5'h00;
   localparam logic [W_CNT-1:0] IDX_CNT = 5'h01;
   localparam logic [W_CNT-1:0] IDX_P0 = 5'h02;
   // reset values
   localparam logic [N_GRP-1:0] GRP_ON_RST = 8'hff;
   typedef enum {CK_START, CK_STOP, CK_ALARM, CK_PHYS, CK_CFGBUS,
      CK_GRPERR, CK_NONE} bsm_ck_t;
   localparam int N_CMD = 6;
   typedef enum logic [2:0] {FK_NOCMD, FK_PWR, FK_CTMO, FK_HTMO,
      FK_PARM} bsm_fk_t;
   typedef enum logic [1:0] {GE_ON, GE_OFF, GE_FAIL} bsm_gek_t;
   typedef enum {S_IDLE, S_EMIT} bsm_st_t;
   typedef struct packed {
      logic [15:0] code;
      logic [15:0] arg0;
      logic [15:0] arg1;
   } bsm_cmd_t;
   typedef struct packed {
      bsm_gek_t kind;
      logic [7:0] grp;
   } bsm_gev_t;
   typedef struct packed {
      logic byte_mode;
      logic [6:0] pd_regs;
      logic [3:0] pcp_regs;
      logic [7:0] id;
   } bsm_mod_t;
   typedef struct packed {
      logic byte_mode;
      logic [6:0] regs;
      logic [7:0] id;
   } bsm_cfgw_t;
endpackage
